/* auto_restart_sequencer.v */
// Automatic restart policy after supply interruptions, with an APB register file.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "restart_seq_defines.vh"

// Functional notes
// - Power stage loss only is brownout; both blackout.
// - Mode 0: no restart, fresh ON needed.
// - Mode 1: blackout clears all, brownout none.
// - Mode 1: no automatic restart.
// - Mode 2: blackout clears supply fault, restarts.
// - Mode 2: outage ON restarts only if ready.
// - Mode 3: clear all, restart, either outage.
// - Mode 3: outage ON ignored.
// - Mode 4: clear supply fault, restart, either outage.
// - Mode 4: outage ON ignored.
// - Mode 5: blackout clears all, restarts; brownout not.
// - Mode 5: outage ON always starts, acknowledging.
// - Mode 6: clear all, restart, either outage.
// - Mode 6: outage ON always restarts, acknowledging.
// - Counter loads attempt count, decrements per failure.
// - All attempts failed raises exhausted fault.
// - Successful start reloads the attempt counter.
module auto_restart_sequencer #(
   parameter CNT_W  = 8,
   parameter ADDR_W = 8
) (
   input  wire              CLK_SYS_I,                 // System clock, 25 MHz.
   input  wire              RST_N_I,                   // Asynchronous reset, active low.
   input  wire              PSEL_I,                    // APB select.
   input  wire              PENABLE_I,                 // APB access phase.
   input  wire              PWRITE_I,                  // APB direction, high for write.
   input  wire [ADDR_W-1:0] PADDR_I,                   // APB byte address.
   input  wire [31:0]       PWDATA_I,                  // APB write data.
   output reg  [31:0]       PRDATA_O,                  // APB read data.
   output wire              PREADY_O,                  // APB ready.
   output wire              PSLVERR_O,                 // APB error, unmapped address.
   input  wire              POWER_STAGE_OK_I,          // Power stage supply present.
   input  wire              CONTROL_SUPPLY_OK_I,       // Control supply present.
   input  wire              ON_CMD_I,                  // ON command from the controller.
   input  wire              READY_TO_RUN_I,            // Drive is ready to run.
   input  wire              RUNNING_I,                 // Drive is running.
   input  wire              ANY_FAULT_I,               // Any fault pending in the store.
   input  wire              SUPPLY_LOSS_FAULT_I,       // Supply loss fault pending.
   input  wire              START_FAILED_I,            // Start attempt hit a new fault.
   output reg               ACK_ALL_FAULTS_O,          // Pulse: acknowledge every fault.
   output reg               ACK_SUPPLY_LOSS_FAULT_O,   // Pulse: acknowledge supply loss fault.
   output reg               AUTO_START_O,              // Level: automatic start request.
   output reg               RESTART_EXHAUSTED_FAULT_O, // Level: all attempts used.
   output wire              RESTART_PENDING_ALARM_O    // Level: restart armed or running.
);

   localparam ST_POWERED = 3'h0;
   localparam ST_OUTAGE  = 3'h1;
   localparam ST_ARMED   = 3'h2;
   localparam ST_START   = 3'h3;

   wire [7:0] pins_sync;
   wire       line_ok;
   wire       ctrl_ok;
   wire       on_lvl;
   wire       ready;
   wire       running;
   wire       fault_any;
   wire       fault_supply;
   wire       start_fail;

   pin_sync #(
      .WIDTH (8)
   ) u_sync (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (RST_N_I),
      .async_i ({START_FAILED_I, SUPPLY_LOSS_FAULT_I, ANY_FAULT_I, RUNNING_I,
                 READY_TO_RUN_I, ON_CMD_I, CONTROL_SUPPLY_OK_I, POWER_STAGE_OK_I}),
      .sync_o  (pins_sync)
   );

   assign line_ok      = pins_sync[0];
   assign ctrl_ok      = pins_sync[1];
   assign on_lvl       = pins_sync[2];
   assign ready        = pins_sync[3];
   assign running      = pins_sync[4];
   assign fault_any    = pins_sync[5];
   assign fault_supply = pins_sync[6];
   assign start_fail   = pins_sync[7];

   reg [2:0]       restart_mode_select;
   reg [CNT_W-1:0] start_attempt_count;
   reg [CNT_W-1:0] attempts_left;
   reg [2:0]       state;
   reg             blackout;
   reg             last_blackout;
   reg             last_brownout;
   reg             ready_at_fail;
   reg             on_seen;
   reg             on_prev;
   reg             fail_prev;
   reg             ack_kind_all;
   reg             set_exhaust;
   reg [1:0]       sync_fill;

   wire pwr_ok    = line_ok & ctrl_ok;
   wire on_rise   = on_lvl & ~on_prev;
   wire fail_rise = start_fail & ~fail_prev;

   // Returns {restart, ack_all, ack_supply} for one power return.
   function [2:0] decide;
      input [2:0] mode;
      input       blk;
      input       on_in_outage;
      input       rdy_at_fail;
      begin
         case (mode)
            `MODE_INHIBIT: begin
               decide = 3'h0;
            end
            `MODE_ACK_ONLY: begin
               decide = {1'b0, blk, 1'b0};
            end
            `MODE_BLK_SUPPLY: begin
               decide = {blk & (~on_in_outage | rdy_at_fail), 1'b0, blk};
            end
            `MODE_ALL_ANY: begin
               decide = 3'h6;
            end
            `MODE_SUPPLY_ANY: begin
               decide = 3'h5;
            end
            `MODE_ALL_BLK: begin
               decide = {blk | on_in_outage, blk | on_in_outage, 1'b0};
            end
            `MODE_ALL_ALWAYS: begin
               decide = 3'h6;
            end
            default: begin
               decide = 3'h0;
            end
         endcase
      end
   endfunction

   wire [2:0] dec = decide(restart_mode_select, blackout, on_seen | on_rise, ready_at_fail);

   // Policy state machine; a supply drop in any state wins over everything else.
   always @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state                   <= ST_OUTAGE;
         blackout                <= 1'b1;
         last_blackout           <= 1'b0;
         last_brownout           <= 1'b0;
         ready_at_fail           <= 1'b0;
         on_seen                 <= 1'b0;
         on_prev                 <= 1'b1;
         sync_fill               <= 2'h0;
         fail_prev               <= 1'b0;
         ack_kind_all            <= 1'b0;
         attempts_left           <= {CNT_W{1'b0}};
         ACK_ALL_FAULTS_O        <= 1'b0;
         ACK_SUPPLY_LOSS_FAULT_O <= 1'b0;
         AUTO_START_O            <= 1'b0;
         set_exhaust             <= 1'b0;
      end else begin
         // The edge detector ignores ON until the synchroniser holds real pin levels,
         // so an ON already high at reset release is not taken for a new command.
         sync_fill               <= {sync_fill[0], 1'b1};
         on_prev                 <= on_lvl | ~sync_fill[1];
         fail_prev               <= start_fail;
         ACK_ALL_FAULTS_O        <= 1'b0;
         ACK_SUPPLY_LOSS_FAULT_O <= 1'b0;
         set_exhaust             <= 1'b0;
         if (!pwr_ok && state != ST_OUTAGE) begin
            state         <= ST_OUTAGE;
            blackout      <= ~ctrl_ok;
            ready_at_fail <= ready;
            on_seen       <= 1'b0;
            AUTO_START_O  <= 1'b0;
         end else begin
            case (state)
               ST_OUTAGE: begin
                  if (!ctrl_ok) begin
                     blackout <= 1'b1;
                  end
                  if (on_rise) begin
                     on_seen <= 1'b1;
                  end
                  if (pwr_ok) begin
                     last_blackout           <= blackout;
                     last_brownout           <= ~blackout;
                     ACK_ALL_FAULTS_O        <= dec[1];
                     ACK_SUPPLY_LOSS_FAULT_O <= dec[0];
                     ack_kind_all            <= dec[1];
                     if (dec[2] && on_lvl) begin
                        if (start_attempt_count == {CNT_W{1'b0}}) begin
                           set_exhaust <= 1'b1;
                           state       <= ST_POWERED;
                        end else begin
                           attempts_left <= start_attempt_count;
                           state         <= ST_ARMED;
                        end
                     end else begin
                        state <= ST_POWERED;
                     end
                  end
               end
               ST_ARMED: begin
                  if (!on_lvl) begin
                     state <= ST_POWERED;
                  end else if (ack_kind_all ? !fault_any : !fault_supply) begin
                     AUTO_START_O <= 1'b1;
                     state        <= ST_START;
                  end
               end
               ST_START: begin
                  if (running) begin
                     AUTO_START_O  <= 1'b0;
                     attempts_left <= start_attempt_count;
                     state         <= ST_POWERED;
                  end else if (fail_rise) begin
                     AUTO_START_O <= 1'b0;
                     if (attempts_left <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                        attempts_left <= {CNT_W{1'b0}};
                        set_exhaust   <= 1'b1;
                        state         <= ST_POWERED;
                     end else begin
                        // A retry acknowledges the new fault in the same manner as before.
                        attempts_left           <= attempts_left - 1'b1;
                        ACK_ALL_FAULTS_O        <= ack_kind_all;
                        ACK_SUPPLY_LOSS_FAULT_O <= ~ack_kind_all;
                        state                   <= ST_ARMED;
                     end
                  end else if (!on_lvl) begin
                     AUTO_START_O <= 1'b0;
                     state        <= ST_POWERED;
                  end
               end
               ST_POWERED: begin
                  state <= ST_POWERED;
               end
               default: begin
                  state <= ST_POWERED;
               end
            endcase
         end
      end
   end

   // Alarm shows a restart that is armed or in progress and drops once the drive runs.
   assign RESTART_PENDING_ALARM_O = (state == ST_ARMED) || (state == ST_START);

   // APB slave: zero wait states, read data captured during the setup cycle.
   wire setup_rd  = PSEL_I & ~PENABLE_I & ~PWRITE_I;
   wire access    = PSEL_I & PENABLE_I;
   wire mapped    = (PADDR_I == `OFS_MODE) || (PADDR_I == `OFS_ATTEMPTS) ||
                    (PADDR_I == `OFS_STATUS) || (PADDR_I == `OFS_LEFT) ||
                    (PADDR_I == `OFS_CLEAR);
   wire wr_strobe = access & PWRITE_I & mapped;
   wire clr_req   = wr_strobe && (PADDR_I == `OFS_CLEAR) && PWDATA_I[`CLR_EXHAUST_BIT];

   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = access & ~mapped;

   reg [31:0] status_word;

   always @* begin
      status_word                    = 32'h0000_0000;
      status_word[`ST_BLACKOUT_BIT]  = last_blackout;
      status_word[`ST_BROWNOUT_BIT]  = last_brownout;
      status_word[`ST_EXHAUST_BIT]   = RESTART_EXHAUSTED_FAULT_O;
      status_word[`ST_ALARM_BIT]     = RESTART_PENDING_ALARM_O;
      status_word[`ST_STATE_LSB+2:`ST_STATE_LSB] = state;
      status_word[`ST_ONSEEN_BIT]    = on_seen;
      status_word[`ST_READY_BIT]     = ready_at_fail;
   end

   always @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         restart_mode_select <= `MODE_RST;
         start_attempt_count <= `ATTEMPTS_RST;
         PRDATA_O            <= 32'h0000_0000;
      end else begin
         if (wr_strobe && PADDR_I == `OFS_MODE) begin
            restart_mode_select <= PWDATA_I[2:0];
         end
         if (wr_strobe && PADDR_I == `OFS_ATTEMPTS) begin
            start_attempt_count <= PWDATA_I[CNT_W-1:0];
         end
         if (setup_rd) begin
            case (PADDR_I)
               `OFS_MODE:     PRDATA_O <= {29'h0000_0000, restart_mode_select};
               `OFS_ATTEMPTS: PRDATA_O <= {{(32-CNT_W){1'b0}}, start_attempt_count};
               `OFS_STATUS:   PRDATA_O <= status_word;
               `OFS_LEFT:     PRDATA_O <= {{(32-CNT_W){1'b0}}, attempts_left};
               default:       PRDATA_O <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Exhausted fault is sticky; a new exhaustion in the clearing cycle wins.
   always @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         RESTART_EXHAUSTED_FAULT_O <= 1'b0;
      end else if (set_exhaust) begin
         RESTART_EXHAUSTED_FAULT_O <= 1'b1;
      end else if (clr_req) begin
         RESTART_EXHAUSTED_FAULT_O <= 1'b0;
      end
   end

endmodule

`default_nettype wire

/* restart_seq_defines.vh */
// Constants for the automatic restart sequencer: register map, fields, resets and modes.
`ifndef RESTART_SEQ_DEFINES_VH
`define RESTART_SEQ_DEFINES_VH

// Register byte offsets.
`define OFS_MODE         8'h00
`define OFS_ATTEMPTS     8'h04
`define OFS_STATUS       8'h08
`define OFS_LEFT         8'h0C
`define OFS_CLEAR        8'h10

// Reset values.
`define MODE_RST         3'h0
`define ATTEMPTS_RST     8'h03

// Status field positions.
`define ST_BLACKOUT_BIT  0
`define ST_BROWNOUT_BIT  1
`define ST_EXHAUST_BIT   2
`define ST_ALARM_BIT     3
`define ST_STATE_LSB     4
`define ST_ONSEEN_BIT    7
`define ST_READY_BIT     8

// Clear register field position.
`define CLR_EXHAUST_BIT  0

// Restart mode values.
`define MODE_INHIBIT     3'h0
`define MODE_ACK_ONLY    3'h1
`define MODE_BLK_SUPPLY  3'h2
`define MODE_ALL_ANY     3'h3
`define MODE_SUPPLY_ANY  3'h4
`define MODE_ALL_BLK     3'h5
`define MODE_ALL_ALWAYS  3'h6

`endif

/* pin_sync.v */
// Two-stage synchroniser for a group of asynchronous input pins.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter WIDTH = 8
) (
   input  wire             clk_i,   // System clock.
   input  wire             rst_n_i, // Asynchronous reset, active low.
   input  wire [WIDTH-1:0] async_i, // Raw pin levels.
   output wire [WIDTH-1:0] sync_o   // Levels after two flip-flops.
);

   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;

   // The first stage may go metastable, so only the second stage reads it.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage1 <= {WIDTH{1'b0}};
         stage2 <= {WIDTH{1'b0}};
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
      end
   end

   assign sync_o = stage2;

endmodule

`default_nettype wire

/* restart_checker_asserts.sv */
// Port-level assertions for the automatic restart sequencer.
`timescale 1ns/1ps
`default_nettype none
module restart_checker #(
   parameter ADDR_W = 8
) (
   input wire logic              CLK_SYS_I,                 // Clock.
   input wire logic              RST_N_I,                   // Reset, active low.
   input wire logic              PSEL_I,                    // Select.
   input wire logic              PENABLE_I,                 // Access phase.
   input wire logic              PWRITE_I,                  // Write.
   input wire logic [ADDR_W-1:0] PADDR_I,                   // Address.
   input wire logic [31:0]       PWDATA_I,                  // Write data.
   input wire logic              ON_CMD_I,                  // ON command.
   input wire logic              RUNNING_I,                 // Drive running.
   input wire logic              ANY_FAULT_I,               // Any fault.
   input wire logic              SUPPLY_LOSS_FAULT_I,       // Supply fault.
   input wire logic              ACK_ALL_FAULTS_O,          // Ack all pulse.
   input wire logic              ACK_SUPPLY_LOSS_FAULT_O,   // Ack supply pulse.
   input wire logic              AUTO_START_O,              // Start request.
   input wire logic              RESTART_EXHAUSTED_FAULT_O, // Exhausted.
   input wire logic              RESTART_PENDING_ALARM_O    // Pending alarm.
);
   logic [2:0] m;
   logic       awaited;
   // The mode register is not visible here, so it is tracked from bus writes.
   always @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         m <= 3'h0;
      end else if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == '0) begin
         m <= PWDATA_I[2:0];
      end
   end
   assign awaited = (m == 3'h2 || m == 3'h4) ? SUPPLY_LOSS_FAULT_I : ANY_FAULT_I;
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   a_mode0_quiet: assert property (
      (m == 3'h0 || m == 3'h7) |-> !(AUTO_START_O || ACK_ALL_FAULTS_O || ACK_SUPPLY_LOSS_FAULT_O))
      else $error("mode 0 acted");
   a_mode1_nostart: assert property ((m == 3'h1) |-> !AUTO_START_O)
      else $error("mode 1 started");
   a_ackall_modes: assert property (
      ACK_ALL_FAULTS_O |-> m inside {3'h1, 3'h3, 3'h5, 3'h6}) else $error("ack all in mode");
   a_acksup_modes: assert property (
      ACK_SUPPLY_LOSS_FAULT_O |-> m inside {3'h2, 3'h4}) else $error("ack supply in mode");
   a_start_fault_gone: assert property (
      $rose(AUTO_START_O) |-> !$past(awaited, 3)) else $error("start with fault");
   a_run_ends_start: assert property (
      $rose(RUNNING_I) |-> ##[1:4] !(AUTO_START_O || RESTART_PENDING_ALARM_O))
      else $error("start kept while running");
   a_on_drop_abort: assert property ($fell(ON_CMD_I) |-> ##[1:4] !AUTO_START_O)
      else $error("start kept without ON");
   a_exhaust_blocks: assert property (
      $rose(AUTO_START_O) |-> !RESTART_EXHAUSTED_FAULT_O) else $error("start after exhaustion");
   a_alarm_start: assert property (AUTO_START_O |-> RESTART_PENDING_ALARM_O)
      else $error("start without alarm");
   c_start: cover property ($rose(AUTO_START_O));
   c_ack_sup: cover property (ACK_SUPPLY_LOSS_FAULT_O);
   c_exhaust: cover property ($rose(RESTART_EXHAUSTED_FAULT_O));
endmodule
bind auto_restart_sequencer restart_checker #(.ADDR_W(ADDR_W)) watch (
   .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .ON_CMD_I(ON_CMD_I),
   .RUNNING_I(RUNNING_I), .ANY_FAULT_I(ANY_FAULT_I), .SUPPLY_LOSS_FAULT_I(SUPPLY_LOSS_FAULT_I),
   .ACK_ALL_FAULTS_O(ACK_ALL_FAULTS_O), .ACK_SUPPLY_LOSS_FAULT_O(ACK_SUPPLY_LOSS_FAULT_O),
   .AUTO_START_O(AUTO_START_O), .RESTART_EXHAUSTED_FAULT_O(RESTART_EXHAUSTED_FAULT_O),
   .RESTART_PENDING_ALARM_O(RESTART_PENDING_ALARM_O));
`default_nettype wire

/* drive_model.sv */
// Drive and fault store model facing the restart sequencer.
`timescale 1ns/1ps
`default_nettype none
module drive_model (
   input  wire logic clk_i,       // Clock.
   input  wire logic rst_n_i,     // Reset, active low.
   input  wire logic ack_all_i,   // Acknowledge every fault.
   input  wire logic ack_sup_i,   // Acknowledge supply loss fault.
   input  wire logic start_i,     // Automatic start request.
   input  wire logic pwr_i,       // Power stage supply present.
   input  wire logic fail_i,      // Make start attempts fail.
   input  wire logic load_i,      // Raise supply loss and another fault.
   output logic      any_fault_o, // Any fault pending.
   output logic      sup_fault_o, // Supply loss fault pending.
   output logic      running_o,   // Drive running.
   output logic      failed_o     // Start attempt failed.
);
   logic       other;
   logic [2:0] cnt;
   assign any_fault_o = sup_fault_o | other;
   // The motor is taken as standing still, so no resynchronisation is modelled.
   // The count saturates so that one held request yields exactly one failure pulse.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sup_fault_o <= 1'h0;
         other <= 1'h0;
         running_o <= 1'h0;
         failed_o <= 1'h0;
         cnt <= 3'h0;
      end else begin
         if (ack_all_i) begin
            sup_fault_o <= 1'h0;
            other <= 1'h0;
         end
         if (ack_sup_i) sup_fault_o <= 1'h0;
         if (load_i) begin
            sup_fault_o <= 1'h1;
            other <= 1'h1;
         end
         if (!start_i) cnt <= 3'h0;
         else if (cnt != 3'h7) cnt <= cnt + 3'h1;
         failed_o <= start_i && cnt == 3'h3 && fail_i;
         if (start_i && cnt == 3'h3 && fail_i) other <= 1'h1;
         if (start_i && cnt == 3'h3 && !fail_i) running_o <= 1'h1;
         if (!pwr_i) running_o <= 1'h0;
      end
   end
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the automatic restart sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
   logic        pst, ctl, on, rdy, fail, load, any_f, sup_f, running, failed;
   logic        ack_all, ack_sup, start, exh, alarm, st_q;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q, b_all, b_sup, b_st;
   logic [31:0] n_all = 32'h0, n_sup = 32'h0, n_st = 32'h0;
   int          errors = 0, check_count = 0;
   // Bus rows: write flag, address, write data, expected read data, expected error.
   logic [73:0] rr [7] = '{{1'h0, 8'h00, 32'h0, 32'h0, 1'h0}, {1'h0, 8'h04, 32'h0, 32'h3, 1'h0},
      {1'h1, 8'h04, 32'h5, 32'h0, 1'h0}, {1'h0, 8'h04, 32'h0, 32'h5, 1'h0},
      {1'h1, 8'h08, 32'hFFFF, 32'h0, 1'h0}, {1'h0, 8'h14, 32'h0, 32'h0, 1'h1},
      {1'h0, 8'h10, 32'h0, 32'h0, 1'h0}};
   // Outage rows: blackout, mode, ack all expected, ack supply expected, start expected.
   logic [6:0]  mr [14] = '{7'h40, 7'h4C, 7'h53, 7'h5D, 7'h63, 7'h6D, 7'h75,
      7'h00, 7'h08, 7'h10, 7'h1D, 7'h23, 7'h28, 7'h35};
   auto_restart_sequencer uut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .POWER_STAGE_OK_I(pst),
      .CONTROL_SUPPLY_OK_I(ctl), .ON_CMD_I(on), .READY_TO_RUN_I(rdy), .RUNNING_I(running),
      .ANY_FAULT_I(any_f), .SUPPLY_LOSS_FAULT_I(sup_f), .START_FAILED_I(failed),
      .ACK_ALL_FAULTS_O(ack_all), .ACK_SUPPLY_LOSS_FAULT_O(ack_sup), .AUTO_START_O(start),
      .RESTART_EXHAUSTED_FAULT_O(exh), .RESTART_PENDING_ALARM_O(alarm));
   drive_model far (.clk_i(clk), .rst_n_i(rst_n), .ack_all_i(ack_all), .ack_sup_i(ack_sup),
      .start_i(start), .pwr_i(pst), .fail_i(fail), .load_i(load), .any_fault_o(any_f),
      .sup_fault_o(sup_f), .running_o(running), .failed_o(failed));
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      n_all <= n_all + {31'h0, ack_all};
      n_sup <= n_sup + {31'h0, ack_sup};
      n_st <= n_st + {31'h0, start & !st_q};
      st_q <= start;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Faults are raised during the outage, as the supply loss itself would do.
   task automatic outage(input logic blk, input logic tog);
      @(posedge clk);
      pst <= 1'h0;
      ctl <= !blk;
      load <= 1'h1;
      @(posedge clk);
      load <= 1'h0;
      if (tog) on <= 1'h0;
      repeat (4) @(posedge clk);
      on <= 1'h1;
      repeat (4) @(posedge clk);
      b_all = n_all;
      b_sup = n_sup;
      b_st = n_st;
      pst <= 1'h1;
      ctl <= 1'h1;
   endtask
   task automatic run(input logic [6:0] r, input logic tog);
      apb(1'h1, 8'h00, {29'h0, r[5:3]});
      outage(r[6], tog);
      repeat (20) @(posedge clk);
      if (!tog) begin
         chk(n_all - b_all, {31'h0, r[2]});
         chk(n_sup - b_sup, {31'h0, r[1]});
      end
      chk(n_st - b_st, {31'h0, r[0]});
      if (r[0]) begin
         apb(1'h0, 8'h0C, 32'h0);
         chk(q, 32'h5);
      end
   endtask
   task automatic summarize;
      if (errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      {psel, penable, pwrite, load, fail} = 5'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      {pst, ctl, on, rdy} = 4'hF;
      rst_n = 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      for (int i = 0; i < 7; i++) begin
         apb(rr[i][73], rr[i][72:65], rr[i][64:33]);
         if (!rr[i][73]) chk(q, rr[i][32:1]);
         chk({31'h0, e}, {31'h0, rr[i][0]});
         chk({31'h0, pready}, 32'h1);
      end
      for (int i = 0; i < 14; i++) run(mr[i], 1'h0);
      rdy <= 1'h0;
      run(7'h50, 1'h1);
      rdy <= 1'h1;
      run(7'h51, 1'h1);
      run(7'h29, 1'h1);
      run(7'h59, 1'h1);
      run(7'h61, 1'h1);
      apb(1'h1, 8'h04, 32'h2);
      fail <= 1'h1;
      outage(1'h1, 1'h0);
      repeat (60) @(posedge clk);
      chk({31'h0, exh}, 32'h1);
      chk(n_st - b_st, 32'h2);
      fail <= 1'h0;
      apb(1'h1, 8'h10, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, exh}, 32'h0);
      // Dropping ON while the start request stands must abandon the restart.
      apb(1'h1, 8'h00, 32'h6);
      outage(1'h0, 1'h0);
      while (start !== 1'h1) @(posedge clk);
      chk({31'h0, alarm}, 32'h1);
      on <= 1'h0;
      repeat (6) @(posedge clk);
      chk({31'h0, start}, 32'h0);
      chk({31'h0, alarm}, 32'h0);
      on <= 1'h1;
      repeat (4) @(posedge clk);
      // Reset in mid-run: outputs clear, and the cold start counts as a blackout.
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      chk({27'h0, ack_all, ack_sup, start, exh, alarm}, 32'h0);
      chk(prdata, 32'h0);
      rst_n <= 1'h1;
      repeat (6) @(posedge clk);
      apb(1'h0, 8'h08, 32'h0);
      chk(q, 32'h1);
      apb(1'h0, 8'h04, 32'h0);
      chk(q, 32'h3);
      summarize();
   end
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      summarize();
   end
endmodule
`default_nettype wire
